// File: cesu_pkg.sv
// Purpose: constants and types shared by the exception and special register unit
// Assumes: register index n sits at byte address 4*n on the register bus
// Notes: indices, the vector base and the machine state and enable reset values are named here once
package cesu_pkg;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_MSTATE = 5'h00;
  localparam logic [4:0] IDX_LINK = 5'h01;
  localparam logic [4:0] IDX_LOOP = 5'h02;
  localparam logic [4:0] IDX_IFLAGS = 5'h03;
  localparam logic [4:0] IDX_TC_RD_LO = 5'h04;
  localparam logic [4:0] IDX_TC_RD_HI = 5'h05;
  localparam logic [4:0] IDX_TC_WR_LO = 5'h06;
  localparam logic [4:0] IDX_TC_WR_HI = 5'h07;
  localparam logic [4:0] IDX_FCAUSE = 5'h08;
  localparam logic [4:0] IDX_FADDR = 5'h09;
  localparam logic [4:0] IDX_CDOWN = 5'h0A;
  localparam logic [4:0] IDX_SPC = 5'h0B;
  localparam logic [4:0] IDX_SSTATE = 5'h0C;
  localparam logic [4:0] IDX_SCR0 = 5'h0D;
  localparam logic [4:0] IDX_SCR3 = 5'h10;
  localparam logic [4:0] IDX_VER = 5'h11;
  localparam logic [4:0] IDX_FPEC = 5'h12;
  localparam logic [4:0] IDX_IRQ_EN_WR = 5'h13;
  localparam logic [4:0] IDX_IRQ_DIS_WR = 5'h14;
  localparam logic [4:0] IDX_UNREC_WR = 5'h15;
  localparam logic [4:0] IDX_EXC_EN = 5'h16;
  localparam logic [4:0] IDX_LAST = 5'h16;
  // ----------------------------------------------------------------
  // Machine state fields and reset values
  // ----------------------------------------------------------------
  localparam int MS_IRQ_EN = 15;
  localparam int MS_USER = 14;
  localparam int MS_RECOV = 1;
  localparam logic [31:0] MSTATE_RST = 32'h0000_0000;
  localparam logic [31:0] EXC_EN_RST = 32'h0000_00FF;
  localparam logic [31:0] VERSION_ID = 32'h0001_0001; // Arbitrary value
  // ----------------------------------------------------------------
  // Exception causes, highest priority first, and vectors
  // ----------------------------------------------------------------
  localparam int EXC_NMI = 0;
  localparam int EXC_EMUL = 1;
  localparam int EXC_PROG = 2;
  localparam int EXC_ALIGN = 3;
  localparam int EXC_DATA = 4;
  localparam int EXC_SYSC = 5;
  localparam int EXC_EXT = 6;
  localparam int EXC_DEC = 7;
  localparam int NEXC = 8;
  localparam logic [31:0] VEC_BASE = 32'h0000_0100;
  // Timer tick divider: one tick every TICK_DIV clocks
  localparam logic [7:0] TICK_DIV = 8'h04;
  typedef enum logic [0:0] {ST_RUN, ST_FLUSH} cesu_state_type;
endpackage : cesu_pkg

// File: cesu_unit.sv
// Purpose: special registers and exception sequencing of a 32-bit core
// Assumes: the pipeline reports the oldest instruction only at retirement
// Notes: register bus is APB with one wait-free access phase
//
// How it works
// - machine state is saved on exception entry and restored on return.
// - every special register except the read-only version register is read and written through the APB port.
// - branch-and-count pulses decrement the loop counter and report zero.
// - integer flags register is a full 32-bit word, implicitly writable.
// - time counter readable by users; writes use separate indices, supervisor only.
// - 32-bit countdown timer ticks on a clock divider and raises an exception.
// - saved pc gets the instruction address, or the next address for a system call; return resumes there.
// - saved state holds machine status; return restores it.
// - version register is read-only; writes are ignored.
// - alignment or data access exceptions load the fault address.
// - alignment or data access exceptions record the fault cause.
// - four scratch registers, supervisor access only.
// - 32-bit floating-point emulation cause register.
// - fetch addresses are always word aligned.
// - effective address is base-or-zero plus immediate or index.
// - an unimplemented optional instruction raises the emulation exception.
// - taking an exception enters supervisor mode and fetches its vector.
// - exceptions other than the non-maskable one are taken only at retirement of the oldest instruction.
// - one exception at a time; only the non-maskable one may interrupt.
// - each exception except the non-maskable one has its own enable bit; disabled ones are never taken.
// - only load/store requests raise a memory request; every request loads the memory address.
// - taking an exception flushes all younger instructions.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/10ps
module cesu_unit (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Retirement and exception sources
  input wire logic RETIRE_READY,
  input wire logic [31:0] RETIRE_PC,
  input wire logic [31:0] RETIRE_NEXT_PC,
  input wire logic EXC_UNIMPL,
  input wire logic EXC_PROGRAM,
  input wire logic EXC_ALIGNMENT,
  input wire logic EXC_DATA_ACCESS,
  input wire logic EXC_SYSCALL,
  input wire logic [31:0] FAULT_ADDR,
  input wire logic [31:0] FAULT_CAUSE,
  input wire logic EXT_IRQ,
  input wire logic NMI_REQ,
  input wire logic RFI_REQ,
  // Implicit register updates
  input wire logic BRCNT,
  input wire logic LINK_WE,
  input wire logic [31:0] LINK_DATA,
  input wire logic FLAGS_WE,
  input wire logic [31:0] FLAGS_DATA,
  input wire logic FPEC_WE,
  input wire logic [31:0] FPEC_DATA,
  // Effective address request
  input wire logic EA_REQ,
  input wire logic EA_LDST,
  input wire logic EA_USE_INDEX,
  input wire logic [4:0] EA_BASE_NUM,
  input wire logic [31:0] EA_BASE,
  input wire logic [31:0] EA_INDEX,
  input wire logic [31:0] EA_IMM,
  // Pipeline controls
  output logic FLUSH,
  output logic FETCH_REDIRECT,
  output logic [31:0] FETCH_ADDR,
  output logic [2:0] EXC_CODE,
  output logic USER_MODE,
  output logic LOOP_ZERO,
  output logic [31:0] LINK_ADDR,
  output logic [31:0] INT_FLAGS,
  output logic MEM_REQ,
  output logic [31:0] MEM_ADDR
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_user_idx(input logic [4:0] i);
    is_user_idx = (i == cesu_pkg::IDX_LINK) || (i == cesu_pkg::IDX_LOOP) ||
                  (i == cesu_pkg::IDX_IFLAGS) || (i == cesu_pkg::IDX_TC_RD_LO) ||
                  (i == cesu_pkg::IDX_TC_RD_HI);
  endfunction : is_user_idx

  function automatic logic [2:0] pick_first(input logic [7:0] v);
    pick_first = 3'h0;
    for (int k = cesu_pkg::NEXC - 1; k >= 0; k--) begin
      if (v[k]) begin
        pick_first = 3'(k);
      end
    end
  endfunction : pick_first

  function automatic logic [31:0] vec_of(input logic [2:0] c);
    vec_of = cesu_pkg::VEC_BASE + {21'h0, c, 8'h00};
  endfunction : vec_of

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] machine_state;
  logic [31:0] return_link_reg;
  logic [31:0] loop_counter;
  logic [31:0] integer_flags_reg;
  logic [63:0] time_counter;
  logic [31:0] fault_cause;
  logic [31:0] fault_address;
  logic [31:0] countdown_timer;
  logic [31:0] saved_pc;
  logic [31:0] saved_state;
  logic [31:0] os_scratch [0:3];
  logic [31:0] fp_emul_cause;
  logic [31:0] exc_enable;
  logic dec_pending;
  logic [7:0] tick_cnt;
  cesu_pkg::cesu_state_type state;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [4:0] idx = PADDR[6:2];
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE & PREADY;
  wire mapped = (PADDR[11:7] == 5'h00) && (PADDR[1:0] == 2'h0) && (idx <= cesu_pkg::IDX_LAST);
  wire is_super = ~machine_state[cesu_pkg::MS_USER];
  wire acc_ok = mapped & (is_super | is_user_idx(idx));
  wire wr_ok = access & PWRITE & acc_ok;
  wire wr_mstate = wr_ok && (idx == cesu_pkg::IDX_MSTATE);
  wire wr_link = wr_ok && (idx == cesu_pkg::IDX_LINK);
  wire wr_loop = wr_ok && (idx == cesu_pkg::IDX_LOOP);
  wire wr_iflags = wr_ok && (idx == cesu_pkg::IDX_IFLAGS);
  wire wr_tc_lo = wr_ok && (idx == cesu_pkg::IDX_TC_WR_LO);
  wire wr_tc_hi = wr_ok && (idx == cesu_pkg::IDX_TC_WR_HI);
  wire wr_fcause = wr_ok && (idx == cesu_pkg::IDX_FCAUSE);
  wire wr_faddr = wr_ok && (idx == cesu_pkg::IDX_FADDR);
  wire wr_cdown = wr_ok && (idx == cesu_pkg::IDX_CDOWN);
  wire wr_spc = wr_ok && (idx == cesu_pkg::IDX_SPC);
  wire wr_sstate = wr_ok && (idx == cesu_pkg::IDX_SSTATE);
  wire wr_scr = wr_ok && (idx >= cesu_pkg::IDX_SCR0) && (idx <= cesu_pkg::IDX_SCR3);
  wire wr_fpec = wr_ok && (idx == cesu_pkg::IDX_FPEC);
  wire wr_irq_en = wr_ok && (idx == cesu_pkg::IDX_IRQ_EN_WR);
  wire wr_irq_dis = wr_ok && (idx == cesu_pkg::IDX_IRQ_DIS_WR);
  wire wr_unrec = wr_ok && (idx == cesu_pkg::IDX_UNREC_WR);
  wire wr_exc_en = wr_ok && (idx == cesu_pkg::IDX_EXC_EN);
  wire [4:0] scr_off = idx - cesu_pkg::IDX_SCR0;
  wire [1:0] scr_sel = scr_off[1:0];

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      cesu_pkg::IDX_MSTATE: rd_mux = machine_state;
      cesu_pkg::IDX_LINK: rd_mux = return_link_reg;
      cesu_pkg::IDX_LOOP: rd_mux = loop_counter;
      cesu_pkg::IDX_IFLAGS: rd_mux = integer_flags_reg;
      cesu_pkg::IDX_TC_RD_LO: rd_mux = time_counter[31:0];
      cesu_pkg::IDX_TC_RD_HI: rd_mux = time_counter[63:32];
      cesu_pkg::IDX_FCAUSE: rd_mux = fault_cause;
      cesu_pkg::IDX_FADDR: rd_mux = fault_address;
      cesu_pkg::IDX_CDOWN: rd_mux = countdown_timer;
      cesu_pkg::IDX_SPC: rd_mux = saved_pc;
      cesu_pkg::IDX_SSTATE: rd_mux = saved_state;
      cesu_pkg::IDX_VER: rd_mux = cesu_pkg::VERSION_ID;
      cesu_pkg::IDX_FPEC: rd_mux = fp_emul_cause;
      cesu_pkg::IDX_EXC_EN: rd_mux = exc_enable;
      default: begin
        if (idx >= cesu_pkg::IDX_SCR0 && idx <= cesu_pkg::IDX_SCR3) begin
          rd_mux = os_scratch[scr_sel];
        end
      end
    endcase
  end

  // Zero-wait answer: ready is raised for the first access cycle only
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PRDATA <= (setup && acc_ok && !PWRITE) ? rd_mux : 32'h0000_0000;
      PSLVERR <= setup & ~acc_ok;
    end
  end

  // ----------------------------------------------------------------
  // Timer divider
  // ----------------------------------------------------------------
  wire tick = (tick_cnt == cesu_pkg::TICK_DIV - 8'h01);
  wire dec_wrap = tick && (countdown_timer == 32'h0000_0000) && !wr_cdown;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Exception arbitration
  // ----------------------------------------------------------------
  wire irq_on = machine_state[cesu_pkg::MS_IRQ_EN];
  wire [7:0] raw = {dec_pending & irq_on, EXT_IRQ & irq_on, EXC_SYSCALL, EXC_DATA_ACCESS,
                    EXC_ALIGNMENT, EXC_PROGRAM, EXC_UNIMPL, 1'b0};
  // Only the retiring oldest instruction may raise an exception
  wire [7:0] eligible = raw & exc_enable[7:0] & {8{RETIRE_READY}};
  // Non-maskable request bypasses enables and the busy state
  wire take_nmi = NMI_REQ;
  wire take_norm = (state == cesu_pkg::ST_RUN) && (|eligible);
  wire take = take_nmi | take_norm;
  wire [2:0] cause = take_nmi ? 3'(cesu_pkg::EXC_NMI) : pick_first(eligible);
  wire faulting = (cause == 3'(cesu_pkg::EXC_ALIGN)) || (cause == 3'(cesu_pkg::EXC_DATA));
  wire do_rfi = RFI_REQ && RETIRE_READY && !take;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= cesu_pkg::ST_RUN;
    end else begin
      state <= take ? cesu_pkg::ST_FLUSH : cesu_pkg::ST_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Machine state
  // ----------------------------------------------------------------
  logic [31:0] next_machine_state;
  always_comb begin
    next_machine_state = machine_state;
    if (take) begin
      next_machine_state[cesu_pkg::MS_USER] = 1'b0;
      next_machine_state[cesu_pkg::MS_IRQ_EN] = 1'b0;
      next_machine_state[cesu_pkg::MS_RECOV] = 1'b0;
    end else if (do_rfi) begin
      next_machine_state = saved_state;
    end else if (wr_mstate) begin
      next_machine_state = PWDATA;
    end else if (wr_irq_en) begin
      next_machine_state[cesu_pkg::MS_IRQ_EN] = 1'b1;
      next_machine_state[cesu_pkg::MS_RECOV] = 1'b1;
    end else if (wr_irq_dis) begin
      next_machine_state[cesu_pkg::MS_IRQ_EN] = 1'b0;
      next_machine_state[cesu_pkg::MS_RECOV] = 1'b1;
    end else if (wr_unrec) begin
      next_machine_state[cesu_pkg::MS_RECOV] = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      machine_state <= cesu_pkg::MSTATE_RST;
    end else begin
      machine_state <= next_machine_state;
    end
  end

  // ----------------------------------------------------------------
  // Save and fault registers
  // ----------------------------------------------------------------
  wire [31:0] save_pc = (cause == 3'(cesu_pkg::EXC_SYSC)) ? RETIRE_NEXT_PC : RETIRE_PC;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      saved_pc <= 32'h0000_0000;
      saved_state <= 32'h0000_0000;
    end else if (take) begin
      saved_pc <= save_pc;
      saved_state <= machine_state;
    end else begin
      if (wr_spc) saved_pc <= PWDATA;
      if (wr_sstate) saved_state <= PWDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fault_address <= 32'h0000_0000;
      fault_cause <= 32'h0000_0000;
    end else if (take && faulting) begin
      fault_address <= FAULT_ADDR;
      fault_cause <= FAULT_CAUSE;
    end else begin
      if (wr_faddr) fault_address <= PWDATA;
      if (wr_fcause) fault_cause <= PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // Fetch redirect and flush
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      FLUSH <= 1'b0;
      FETCH_REDIRECT <= 1'b0;
      FETCH_ADDR <= 32'h0000_0000;
      EXC_CODE <= 3'h0;
    end else begin
      FLUSH <= take | do_rfi;
      FETCH_REDIRECT <= take | do_rfi;
      if (take) begin
        FETCH_ADDR <= vec_of(cause);
        EXC_CODE <= cause;
      end else if (do_rfi) begin
        FETCH_ADDR <= {saved_pc[31:2], 2'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // User registers and floating-point emulation cause
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      loop_counter <= 32'h0000_0000;
      LOOP_ZERO <= 1'b0;
    end else if (wr_loop) begin
      loop_counter <= PWDATA;
      LOOP_ZERO <= (PWDATA == 32'h0000_0000);
    end else if (BRCNT) begin
      loop_counter <= loop_counter - 32'h0000_0001;
      LOOP_ZERO <= (loop_counter == 32'h0000_0001);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      return_link_reg <= 32'h0000_0000;
      integer_flags_reg <= 32'h0000_0000;
      fp_emul_cause <= 32'h0000_0000;
    end else begin
      if (wr_link) return_link_reg <= PWDATA;
      else if (LINK_WE) return_link_reg <= LINK_DATA;
      if (wr_iflags) integer_flags_reg <= PWDATA;
      else if (FLAGS_WE) integer_flags_reg <= FLAGS_DATA;
      if (wr_fpec) fp_emul_cause <= PWDATA;
      else if (FPEC_WE) fp_emul_cause <= FPEC_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      time_counter <= 64'h0000_0000_0000_0000;
    end else if (wr_tc_lo) begin
      time_counter[31:0] <= PWDATA;
    end else if (wr_tc_hi) begin
      time_counter[63:32] <= PWDATA;
    end else if (tick) begin
      time_counter <= time_counter + 64'h0000_0000_0000_0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      countdown_timer <= 32'h0000_0000;
    end else if (wr_cdown) begin
      countdown_timer <= PWDATA;
    end else if (tick) begin
      countdown_timer <= countdown_timer - 32'h0000_0001;
    end
  end

  // A wrap in the same cycle as the take keeps the request alive
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dec_pending <= 1'b0;
    end else if (dec_wrap) begin
      dec_pending <= 1'b1;
    end else if (take && cause == 3'(cesu_pkg::EXC_DEC)) begin
      dec_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Supervisor scratch and enables
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int k = 0; k < 4; k++) begin
        os_scratch[k] <= 32'h0000_0000;
      end
      exc_enable <= cesu_pkg::EXC_EN_RST;
    end else begin
      if (wr_scr) os_scratch[scr_sel] <= PWDATA;
      if (wr_exc_en) exc_enable <= PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  wire [31:0] ea_base = (EA_BASE_NUM == 5'h00) ? 32'h0000_0000 : EA_BASE;
  wire [31:0] effective_addr = ea_base + (EA_USE_INDEX ? EA_INDEX : EA_IMM);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      MEM_REQ <= 1'b0;
      MEM_ADDR <= 32'h0000_0000;
    end else begin
      // Computational requests never reach memory
      MEM_REQ <= EA_REQ & EA_LDST;
      if (EA_REQ) MEM_ADDR <= effective_addr;
    end
  end

  assign USER_MODE = machine_state[cesu_pkg::MS_USER];
  assign LINK_ADDR = return_link_reg;
  assign INT_FLAGS = integer_flags_reg;
endmodule : cesu_unit

// File: cesu_pipe_model.sv
// Purpose: retirement stage model that feeds the exception unit
// Assumes: the sequencer raises req for one instruction and drops it later
// Notes: the instruction waits at retirement until it is flushed
`timescale 1ns/10ps
module cesu_pipe_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sequencer side
  input wire logic req,
  input wire logic [4:0] causes,
  input wire logic rfi,
  input wire logic [31:0] pc,
  // Unit side
  input wire logic flush,
  output logic retire_ready,
  output logic [4:0] exc,
  output logic rfi_req,
  output logic [31:0] retire_pc,
  output logic [31:0] next_pc
);
  logic gone;
  always_ff @(posedge clk) begin
    if (!rst_n || !req) begin
      gone <= 1'b0;
    end else if (flush) begin
      gone <= 1'b1;
    end
  end
  // Only the oldest instruction is offered, earlier ones retired
  assign retire_ready = req && !gone && !flush;
  assign exc = retire_ready ? causes : 5'h00;
  assign rfi_req = retire_ready && rfi;
  // Address is meaningless off retirement, so it is scrambled
  assign retire_pc = retire_ready ? pc : ~pc;
  assign next_pc = retire_pc + 32'h4;
endmodule : cesu_pipe_model

// File: cesu_unit_assertions.sv
// Purpose: port checks of the exception and register unit
// Assumes: exception enables are at their reset mask when taken
// Notes: bound to every instance of the unit
`timescale 1ns/10ps
module cesu_unit_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Pipeline side
  input wire logic RETIRE_READY,
  input wire logic NMI_REQ,
  input wire logic RFI_REQ,
  input wire logic EA_REQ,
  input wire logic EA_LDST,
  input wire logic FLUSH,
  input wire logic FETCH_REDIRECT,
  input wire logic [31:0] FETCH_ADDR,
  input wire logic [2:0] EXC_CODE,
  input wire logic USER_MODE,
  input wire logic MEM_REQ
);
  logic rfi_d;
  wire logic setup = PSEL && !PENABLE;
  wire logic sup_idx = (PADDR[6:2] == 5'h00) || (PADDR[6:2] > 5'h05);
  // A return also flushes, so vector checks must skip it
  always_ff @(posedge CLK) begin
    rfi_d <= RST_N && RFI_REQ && RETIRE_READY;
  end
  // ----
  // Checks
  // ----
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_apb_answer: assert property (setup |=> PREADY ##1 !PREADY)
    else $error("access phase not answered exactly once");
  chk_user_refused: assert property (setup && USER_MODE && sup_idx |=> PSLVERR)
    else $error("user access to supervisor register accepted");
  chk_flush_single: assert property (FLUSH && !NMI_REQ |=> !FLUSH)
    else $error("two exceptions handled back to back");
  chk_redirect_pair: assert property (FLUSH == FETCH_REDIRECT)
    else $error("redirect and flush disagree");
  chk_fetch_aligned: assert property (FETCH_REDIRECT |-> FETCH_ADDR[1:0] == 2'b00)
    else $error("fetch address not word aligned");
  chk_vector_addr: assert property (FLUSH && !rfi_d |->
    FETCH_ADDR == cesu_pkg::VEC_BASE + {21'h0, EXC_CODE, 8'h00})
    else $error("wrong exception vector");
  chk_super_entry: assert property (FLUSH && !rfi_d |-> !USER_MODE)
    else $error("exception entry left user mode set");
  chk_mem_ldst: assert property (MEM_REQ == $past(EA_REQ && EA_LDST))
    else $error("memory request without load or store");
  cover property (FLUSH && EXC_CODE == 3'h7);
  cover property (rfi_d);
  cover property (PREADY && PSLVERR);
endmodule : cesu_unit_chk

bind cesu_unit cesu_unit_chk chk_i (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RETIRE_READY(RETIRE_READY), .NMI_REQ(NMI_REQ),
  .RFI_REQ(RFI_REQ), .EA_REQ(EA_REQ), .EA_LDST(EA_LDST), .FLUSH(FLUSH),
  .FETCH_REDIRECT(FETCH_REDIRECT), .FETCH_ADDR(FETCH_ADDR), .EXC_CODE(EXC_CODE),
  .USER_MODE(USER_MODE), .MEM_REQ(MEM_REQ)
);

// File: tb_cesu_unit.sv
// Purpose: self-checking bench of the exception and register unit
// Assumes: the pipeline model holds an instruction until it is flushed
// Notes: registers are reached through the APB task and through the implicit update and output ports
`timescale 1ns/10ps
module tb_cesu_unit;
  logic clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, brcnt = 1'b0;
  logic imp_we = 1'b0, nmi = 1'b0, ea_req = 1'b0, ea_ldst = 1'b0, ea_ix = 1'b0;
  logic req = 1'b0, rfi = 1'b0, rr, rfi_req, pready, pslverr, flush, user, lzero, mreq;
  logic [4:0] causes = 5'h00, ea_bn = 5'h00, exc;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, pc = 32'h0, faddr = 32'h0, fcause = 32'h0, imp = 32'hC3A5_0F1C;
  logic [31:0] prdata, rpc, npc, fetch, link, iflags, maddr, last, pv, spc;
  logic [2:0] code;
  logic [4:0] sreg [0:9] = '{5'h01, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h12};
  int miscompares = 0, compares = 0;

  cesu_unit dut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RETIRE_READY(rr), .RETIRE_PC(rpc), .RETIRE_NEXT_PC(npc), .EXC_UNIMPL(exc[0]),
    .EXC_PROGRAM(exc[1]), .EXC_ALIGNMENT(exc[2]), .EXC_DATA_ACCESS(exc[3]),
    .EXC_SYSCALL(exc[4]), .FAULT_ADDR(faddr), .FAULT_CAUSE(fcause), .EXT_IRQ(1'b0),
    .NMI_REQ(nmi), .RFI_REQ(rfi_req), .BRCNT(brcnt), .LINK_WE(imp_we), .LINK_DATA(imp),
    .FLAGS_WE(imp_we), .FLAGS_DATA(imp), .FPEC_WE(imp_we), .FPEC_DATA(imp),
    .EA_REQ(ea_req), .EA_LDST(ea_ldst), .EA_USE_INDEX(ea_ix), .EA_BASE_NUM(ea_bn),
    .EA_BASE(32'h0000_1000), .EA_INDEX(32'h0000_0020), .EA_IMM(32'h0000_0008),
    .FLUSH(flush), .FETCH_REDIRECT(), .FETCH_ADDR(fetch), .EXC_CODE(code),
    .USER_MODE(user), .LOOP_ZERO(lzero), .LINK_ADDR(link), .INT_FLAGS(iflags),
    .MEM_REQ(mreq), .MEM_ADDR(maddr)
  );
  cesu_pipe_model pipe (
    .clk(clk), .rst_n(rst_n), .req(req), .causes(causes), .rfi(rfi), .pc(pc),
    .flush(flush), .retire_ready(rr), .exc(exc), .rfi_req(rfi_req), .retire_pc(rpc),
    .next_pc(npc)
  );

  task automatic close_out();
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Low-word time reads drift with the tick, so the caller judges them
  task automatic rw(input logic w, input logic [4:0] i, input logic [31:0] d,
                    input logic [31:0] e, input logic ee);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {5'h00, i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      close_out();
    end
    last = prdata;
    check({31'h0, pslverr}, {31'h0, ee});
    if (!w && i != cesu_pkg::IDX_TC_RD_LO) check(prdata, e);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : rw

  task automatic go(input logic [4:0] c, input logic r, input logic exp_take);
    int n;
    n = 0;
    req <= 1'b1;
    causes <= c;
    rfi <= r;
    do begin
      @(posedge clk);
      n++;
    end while (flush !== 1'b1 && n < 40);
    check({31'h0, flush}, {31'h0, exp_take});
    if (flush !== exp_take) close_out();
    req <= 1'b0;
    @(posedge clk);
  endtask : go

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rw(1'b0, cesu_pkg::IDX_MSTATE, 32'h0, cesu_pkg::MSTATE_RST, 1'b0);
    rw(1'b0, cesu_pkg::IDX_EXC_EN, 32'h0, cesu_pkg::EXC_EN_RST, 1'b0);
    rw(1'b1, cesu_pkg::IDX_VER, 32'h0, 32'h0, 1'b0);
    rw(1'b0, cesu_pkg::IDX_VER, 32'h0, cesu_pkg::VERSION_ID, 1'b0);
    rw(1'b0, 5'h17, 32'h0, 32'h0, 1'b1);
    for (int j = 0; j < 10; j++) begin
      rw(1'b1, sreg[j], ~{27'h0, sreg[j]}, 32'h0, 1'b0);
      rw(1'b0, sreg[j], 32'h0, ~{27'h0, sreg[j]}, 1'b0);
    end
    rw(1'b1, cesu_pkg::IDX_TC_WR_LO, 32'h10, 32'h0, 1'b0);
    rw(1'b0, cesu_pkg::IDX_TC_RD_LO, 32'h0, 32'h0, 1'b0);
    check({31'h0, (last - 32'h10) < 32'h3}, 32'h1);
    rw(1'b1, cesu_pkg::IDX_LOOP, 32'h2, 32'h0, 1'b0);
    for (int j = 0; j < 2; j++) begin
      brcnt <= 1'b1;
      @(posedge clk);
      brcnt <= 1'b0;
      @(posedge clk);
      check({31'h0, lzero}, 32'(j));
    end
    imp_we <= 1'b1;
    @(posedge clk);
    imp_we <= 1'b0;
    @(posedge clk);
    check(link, imp);
    check(iflags, imp);
    rw(1'b0, cesu_pkg::IDX_FPEC, 32'h0, imp, 1'b0);
    for (int j = 0; j < 3; j++) begin
      ea_req <= 1'b1;
      ea_bn <= (j == 0) ? 5'h00 : 5'h03;
      ea_ix <= (j == 1);
      ea_ldst <= (j != 2);
      @(posedge clk);
      ea_req <= 1'b0;
      @(posedge clk);
      check({31'h0, mreq}, {31'h0, j != 2});
      if (j != 2) check(maddr, (j == 0) ? 32'h8 : 32'h1020);
    end
    // Enter user mode so each take must also raise privilege
    rw(1'b1, cesu_pkg::IDX_MSTATE, 32'h4000, 32'h0, 1'b0);
    for (int k = 1; k <= 5; k++) begin
      pv = 32'h0000_2000 + 32'(k) * 32'h40;
      spc = (k == 5) ? pv + 32'h4 : pv;
      pc <= pv;
      faddr <= ~pv;
      fcause <= pv;
      if (k == 2) rw(1'b0, cesu_pkg::IDX_SCR0, 32'h0, 32'h0, 1'b1);
      go(5'h1F << (k - 1), 1'b0, 1'b1);
      check({29'h0, code}, 32'(k));
      check(fetch, cesu_pkg::VEC_BASE + 32'(k) * 32'h100);
      check({31'h0, user}, 32'h0);
      rw(1'b0, cesu_pkg::IDX_SSTATE, 32'h0, 32'h4000, 1'b0);
      rw(1'b0, cesu_pkg::IDX_SPC, 32'h0, spc, 1'b0);
      if (k inside {3, 4}) begin
        rw(1'b0, cesu_pkg::IDX_FADDR, 32'h0, ~pv, 1'b0);
        rw(1'b0, cesu_pkg::IDX_FCAUSE, 32'h0, pv, 1'b0);
      end
      go(5'h00, 1'b1, 1'b1);
      check(fetch, spc);
      check({31'h0, user}, 32'h1);
    end
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    @(posedge clk);
    check({31'h0, flush}, 32'h1);
    check(fetch, cesu_pkg::VEC_BASE);
    @(posedge clk);
    rw(1'b1, cesu_pkg::IDX_EXC_EN, 32'hFB, 32'h0, 1'b0);
    go(5'h02, 1'b0, 1'b0);
    rw(1'b1, cesu_pkg::IDX_EXC_EN, 32'hFF, 32'h0, 1'b0);
    rw(1'b1, cesu_pkg::IDX_CDOWN, 32'h3, 32'h0, 1'b0);
    rw(1'b1, cesu_pkg::IDX_IRQ_EN_WR, 32'h0, 32'h0, 1'b0);
    go(5'h00, 1'b0, 1'b1);
    check(fetch, cesu_pkg::VEC_BASE + 32'h700);
    close_out();
  end
endmodule : tb_cesu_unit
